// ---- rtl/pmw_pkg.sv ----
/*
  Package for the power mode and wake-up controller: register indices,
  field positions, reset values, source numbering, vector table, modes.
  Assumes a 32-bit Avalon-MM slave, byte address = 4 x register index.
*/
`default_nettype none
package pmw_pkg;
  // ****************************************
  // Register indices and reset values
  // ****************************************
  localparam int unsigned ADDR_W = 10;
  localparam logic [7:0] IDX_PWR_CTRL = 8'h87;
  localparam logic [7:0] IDX_CLK_CTRL = 8'hd8;
  localparam logic [7:0] IDX_AUXILIARY_CONTROL_TWO = 8'hf7;
  localparam logic [7:0] IDX_IRQ_EN = 8'h40;
  localparam logic [7:0] IDX_IRQ_FLAG = 8'h41;
  localparam logic [7:0] IDX_PORT_WAKE = 8'h42;
  localparam logic [7:0] IDX_STATUS = 8'h43;
  localparam logic [7:0] PWR_CTRL_RST = 8'h00;
  localparam logic [7:0] CLK_CTRL_RST = 8'h23;
  localparam logic [7:0] AUXILIARY_CONTROL_TWO_RST = 8'h06;
  localparam logic [31:0] IRQ_EN_RST = 32'h0000_0000;
  localparam logic [31:0] PORT_WAKE_RST = 32'h0000_0000;
  // ****************************************
  // Field positions
  // ****************************************
  localparam int unsigned PWR_DOZE_BIT = 0;
  localparam int unsigned PWR_SLEEP_BIT = 1;
  localparam logic [7:0] PWR_KEEP_MASK = 8'h8c;
  localparam int unsigned CLK_SSTOP_BIT = 5;
  localparam int unsigned CLK_PGATE_BIT = 4;
  localparam int unsigned CLK_FSTOP_BIT = 3;
  localparam int unsigned CLK_SEL_BIT = 2;
  localparam int unsigned AUXILIARY_CONTROL_TWO_BGOUT_BIT = 4;
  localparam int unsigned AUXILIARY_CONTROL_TWO_WDT_LSB = 6;
  localparam int unsigned IRQ_GLOBAL_BIT = 15;
  localparam int unsigned STAT_MODE_LSB = 16;
  // ****************************************
  // Sources, vectors, timing
  // ****************************************
  localparam int unsigned NUM_SRC = 13;
  localparam int unsigned SRC_EXT0 = 0;
  localparam int unsigned SRC_EXT1 = 2;
  localparam int unsigned SRC_T3 = 6;
  localparam int unsigned SRC_PCHG = 7;
  localparam int unsigned SRC_EXT2 = 8;
  localparam logic [15:0] VEC_NONE = 16'h0000;
  localparam logic [15:0] VEC_TABLE [NUM_SRC] = '{
    16'h0003, 16'h000b, 16'h0013, 16'h001b, 16'h0023, 16'h002b, 16'h003b,
    16'h0043, 16'h004b, 16'h0053, 16'h005b, 16'h0063, 16'h0073};
  localparam logic [3:0] DIV_SETTLE_CYC = 4'hf;
  localparam logic [1:0] WDT_ALWAYS = 2'h3;

  typedef enum logic [4:0] {
    PMW_FAST = 5'h01,
    PMW_SLOW = 5'h02,
    PMW_IDLE = 5'h04,
    PMW_HALT = 5'h08,
    PMW_STOP = 5'h10
  } pmw_mode_t;

  typedef struct packed {
    logic [ADDR_W-1:0] address;
    logic read;
    logic write;
    logic [31:0] writedata;
    logic [3:0] byteenable;
  } pmw_avs_req_t;

  typedef struct packed {
    logic cpu_run;
    logic fast_osc_en;
    logic slow_osc_en;
    logic periph_clk_en;
    logic timer3_clk_en;
    logic wdt_reset_en;
  } pmw_clk_gate_t;
endpackage
`default_nettype wire

// ---- rtl/pmw_power_ctrl.sv ----
/*
  Power mode and wake-up controller: Fast/Slow/Idle/Halt/Stop sequencing,
  clock gating, system clock select and prescaler, interrupt flags and
  vector identification. Assumes peripherals pulse irq_event_i on
  sys_clk_i; pins are asynchronous and synchronised here.
*/
`timescale 1ns/10ps
`default_nettype none

// Contract
// - Five modes: Fast, Slow, Idle, Halt and Stop.
// - Writing one to doze_request_bit enters Idle.
// - Idle stops the core, peripherals run, either clock source.
// - periph_clock_gate_idle stops timer0-2, UART, ADC clocks in Idle.
// - Idle ends on reset or any enabled interrupt.
// - sleep_request_bit with slow_osc_stop_in_deep clear enters Halt.
// - Halt stops all clocks except Timer3 and watchdog.
// - Halt ends on reset, pin wake or Timer3 interrupt.
// - sleep_request_bit enters Stop; slow clock stops there when set.
// - Stop stops every clock except the watchdog.
// - Stop ends only on reset or pin wake.
// - No Halt or Stop while an enabled external pin is low.
// - fast_osc_stop stops fast oscillator; changeable only in Slow.
// - sysclk_source_select 0 slow, 1 fast; changeable only if fast runs.
// - Divider codes 00..11 give 16,4,2,1; effective within 16 cycles.
// - bandgap_pin_output_enable routes reference voltage to P3.2.
// - Thirteen sources, each with its own enable bit.
// - Enabled interrupts wake Idle; pin sources wake Halt and Stop.
// - Every event sets its flag regardless of its enable.
// - Pin source vectors 0003, 0013, 0043, 004B.
// - Other vectors 000B to 0073 as tabled, shared flags merged.
// - Vectors 0033 and 006B are never assigned.
// - Watchdog reset: 0x off, 10 Fast/Slow only, 11 always.
// - Enabled external pin wakes Halt/Stop regardless of global enable.
// - Per-port-pin wake enable gates wake and pin-change flag.
module pmw_power_ctrl
  import pmw_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_b_i,
  // Avalon-MM slave
  input wire pmw_avs_req_t avs_req_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  // Wake and event sources
  input wire logic [2:0] ext_irq_pin_i,
  input wire logic [31:0] port_pin_i,
  input wire logic [NUM_SRC-1:0] irq_event_i,
  // Clock and mode control
  output pmw_clk_gate_t clk_gate_o,
  output logic [4:0] mode_o,
  output logic sysclk_sel_fast_o,
  output logic sysclk_tick_o,
  output logic wake_pulse_o,
  output logic bandgap_to_p32_o,
  // Interrupt identification
  output logic [NUM_SRC-1:0] irq_flags_o,
  output logic irq_pending_o,
  output logic [15:0] irq_vector_o
);
  // ****************************************
  // Bus slave
  // ****************************************
  logic ack_r;
  logic [31:0] rdata_r;
  wire logic req = avs_req_i.read | avs_req_i.write;
  wire logic wr_go = avs_req_i.write & ack_r;
  wire logic [7:0] idx = avs_req_i.address[ADDR_W-1:2];
  wire logic be0 = avs_req_i.byteenable[0];
  wire logic [31:0] wd = avs_req_i.writedata;
  wire logic [31:0] be_mask = {{8{avs_req_i.byteenable[3]}},
    {8{avs_req_i.byteenable[2]}}, {8{avs_req_i.byteenable[1]}},
    {8{be0}}};
  wire logic wr_pwr = wr_go & be0 & (idx == IDX_PWR_CTRL);
  wire logic wr_clk = wr_go & be0 & (idx == IDX_CLK_CTRL);
  wire logic wr_aux = wr_go & be0 & (idx == IDX_AUXILIARY_CONTROL_TWO);
  wire logic wr_ien = wr_go & (idx == IDX_IRQ_EN);
  wire logic wr_flg = wr_go & (idx == IDX_IRQ_FLAG);
  wire logic wr_pwk = wr_go & (idx == IDX_PORT_WAKE);
  // One wait cycle, then the answer
  assign avs_waitrequest_o = req & ~ack_r;
  assign avs_readdata_o = rdata_r;

  // ****************************************
  // Pin synchronisers
  // ****************************************
  logic [34:0] pin_meta_r;
  logic [34:0] pin_sync_r;
  logic [34:0] pin_last_r;
  always_ff @(posedge sys_clk_i) begin
    pin_meta_r <= {port_pin_i, ext_irq_pin_i};
    pin_sync_r <= pin_meta_r;
    pin_last_r <= pin_sync_r;
  end

  // ****************************************
  // Registers
  // ****************************************
  pmw_mode_t mode_r;
  pmw_mode_t mode_nxt;
  logic doze_r;
  logic sleep_r;
  logic [7:0] pwr_keep_r;
  logic sstop_r;
  logic pgate_r;
  logic fstop_r;
  logic sel_r;
  logic [1:0] div_req_r;
  logic [1:0] div_eff_r;
  logic [3:0] settle_r;
  logic [3:0] pre_r;
  logic tick_r;
  logic wake_r;
  logic [7:0] aux_r;
  logic [31:0] ien_r;
  logic [31:0] pwk_r;
  logic [NUM_SRC-1:0] flag_r;
  logic [NUM_SRC-1:0] flag_nxt;
  logic [NUM_SRC-1:0] ev;
  logic [15:0] vec;

  wire logic glb_en = ien_r[IRQ_GLOBAL_BIT];
  wire logic [NUM_SRC-1:0] src_en = ien_r[NUM_SRC-1:0];
  wire logic [2:0] ext_en = {src_en[SRC_EXT2], src_en[SRC_EXT1],
    src_en[SRC_EXT0]};
  wire logic [2:0] ext_fall = pin_last_r[2:0] & ~pin_sync_r[2:0];
  wire logic port_hit =
    |((pin_last_r[34:3] ^ pin_sync_r[34:3]) & pwk_r);
  // An enabled pin held low gives no falling edge to wake on, so deep sleep is refused
  wire logic refuse_deep = |(~pin_sync_r[2:0] & ext_en);
  wire logic pin_wake = (|(ext_fall & ext_en)) | port_hit;
  wire logic [NUM_SRC-1:0] en_pend = flag_r & src_en & {NUM_SRC{glb_en}};
  wire logic in_run = (mode_r == PMW_FAST) | (mode_r == PMW_SLOW);
  wire logic sleep_go = wr_pwr & wd[PWR_SLEEP_BIT] & ~refuse_deep & in_run;
  wire logic doze_go = wr_pwr & wd[PWR_DOZE_BIT] & in_run;
  wire logic t3_wake = ev[SRC_T3] & src_en[SRC_T3];
  wire pmw_mode_t run_mode = sel_r ? PMW_FAST : PMW_SLOW;
  wire logic wake = (mode_nxt != mode_r) & ~in_run;
  wire logic fstop_new = (mode_r == PMW_SLOW) ? wd[CLK_FSTOP_BIT] : fstop_r;
  wire logic sel_ok = ~fstop_r & ~fstop_new;
  wire logic [3:0] pre_mask = (div_eff_r == 2'h0) ? 4'hf :
    (div_eff_r == 2'h1) ? 4'h3 : (div_eff_r == 2'h2) ? 4'h1 : 4'h0;
  wire logic [31:0] rd_mux =
    (idx == IDX_PWR_CTRL) ? {24'h0, (pwr_keep_r & PWR_KEEP_MASK) |
      {6'h0, sleep_r, doze_r}} :
    (idx == IDX_CLK_CTRL) ? {26'h0, sstop_r, pgate_r, fstop_r, sel_r,
      div_req_r} :
    (idx == IDX_AUXILIARY_CONTROL_TWO) ? {24'h0, aux_r} :
    (idx == IDX_IRQ_EN) ? ien_r :
    (idx == IDX_IRQ_FLAG) ? {19'h0, flag_r} :
    (idx == IDX_PORT_WAKE) ? pwk_r :
    (idx == IDX_STATUS) ? {11'h0, mode_r, vec} : 32'h0;

  // ****************************************
  // Event flags
  // ****************************************
  // Pin sources come from the synchronised pins, the rest from peripherals
  for (genvar i = 0; i < NUM_SRC; i++) begin : g_src
    if (i == SRC_EXT0) begin : g_e0
      assign ev[i] = ext_fall[0];
    end else if (i == SRC_EXT1) begin : g_e1
      assign ev[i] = ext_fall[1];
    end else if (i == SRC_EXT2) begin : g_e2
      assign ev[i] = ext_fall[2];
    end else if (i == SRC_PCHG) begin : g_pc
      assign ev[i] = port_hit;
    end else begin : g_pr
      assign ev[i] = irq_event_i[i];
    end
    // Set wins over a software clear in the same cycle
    assign flag_nxt[i] = (flag_r[i] & ~(wr_flg & wd[i] & be_mask[i]))
      | ev[i];
  end

  // Lowest vector wins; level arbitration lives in the core
  always_comb begin
    vec = VEC_NONE;
    for (int k = NUM_SRC - 1; k >= 0; k--) begin
      if (en_pend[k]) begin
        vec = VEC_TABLE[k];
      end
    end
  end

  // ****************************************
  // Mode sequencer
  // ****************************************
  always_comb begin
    case (mode_r)
      PMW_FAST, PMW_SLOW: begin
        if (sleep_go) begin
          mode_nxt = sstop_r ? PMW_STOP : PMW_HALT;
        end else if (doze_go) begin
          mode_nxt = PMW_IDLE;
        end else begin
          mode_nxt = run_mode;
        end
      end
      PMW_IDLE: begin
        mode_nxt = (|en_pend) ? run_mode : PMW_IDLE;
      end
      PMW_HALT: begin
        mode_nxt = (pin_wake | t3_wake) ? run_mode : PMW_HALT;
      end
      PMW_STOP: begin
        mode_nxt = pin_wake ? run_mode : PMW_STOP;
      end
      default: begin
        mode_nxt = run_mode;
      end
    endcase
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      ack_r <= 1'b0;
      rdata_r <= 32'h0;
      mode_r <= PMW_SLOW;
      doze_r <= PWR_CTRL_RST[PWR_DOZE_BIT];
      sleep_r <= PWR_CTRL_RST[PWR_SLEEP_BIT];
      pwr_keep_r <= PWR_CTRL_RST;
      wake_r <= 1'b0;
      flag_r <= '0;
    end else begin
      ack_r <= req & ~ack_r;
      rdata_r <= (req & ~ack_r) ? rd_mux : rdata_r;
      mode_r <= mode_nxt;
      doze_r <= wake ? 1'b0 : (doze_r | (doze_go & ~sleep_go));
      sleep_r <= wake ? 1'b0 : (sleep_r | sleep_go);
      pwr_keep_r <= wr_pwr ? wd[7:0] : pwr_keep_r;
      wake_r <= wake;
      flag_r <= flag_nxt;
    end
  end

  // ****************************************
  // Clock control and prescaler
  // ****************************************
  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      sstop_r <= CLK_CTRL_RST[CLK_SSTOP_BIT];
      pgate_r <= CLK_CTRL_RST[CLK_PGATE_BIT];
      fstop_r <= CLK_CTRL_RST[CLK_FSTOP_BIT];
      sel_r <= CLK_CTRL_RST[CLK_SEL_BIT];
      div_req_r <= CLK_CTRL_RST[1:0];
      div_eff_r <= CLK_CTRL_RST[1:0];
      settle_r <= 4'h0;
      pre_r <= 4'h0;
      tick_r <= 1'b0;
      aux_r <= AUXILIARY_CONTROL_TWO_RST;
      ien_r <= IRQ_EN_RST;
      pwk_r <= PORT_WAKE_RST;
    end else begin
      if (wr_clk) begin
        sstop_r <= wd[CLK_SSTOP_BIT];
        pgate_r <= wd[CLK_PGATE_BIT];
        fstop_r <= fstop_new;
        sel_r <= sel_ok ? wd[CLK_SEL_BIT] : sel_r;
        div_req_r <= wd[1:0];
      end
      // New divider lands at most 16 cycles after the write
      settle_r <= (div_req_r == div_eff_r || settle_r == DIV_SETTLE_CYC) ?
        4'h0 : settle_r + 4'h1;
      if (settle_r == DIV_SETTLE_CYC) begin
        div_eff_r <= div_req_r;
      end
      pre_r <= pre_r + 4'h1;
      tick_r <= (pre_r & pre_mask) == pre_mask;
      aux_r <= wr_aux ? wd[7:0] : aux_r;
      ien_r <= wr_ien ? ((ien_r & ~be_mask) | (wd & be_mask)) :
        ien_r;
      pwk_r <= wr_pwk ? ((pwk_r & ~be_mask) | (wd & be_mask)) : pwk_r;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  wire logic [1:0] wdt_mode = aux_r[AUXILIARY_CONTROL_TWO_WDT_LSB +: 2];
  assign clk_gate_o.cpu_run = in_run;
  assign clk_gate_o.fast_osc_en = ~fstop_r &
    (in_run | mode_r == PMW_IDLE);
  assign clk_gate_o.slow_osc_en = (mode_r != PMW_STOP);
  assign clk_gate_o.periph_clk_en = in_run |
    ((mode_r == PMW_IDLE) & ~pgate_r);
  assign clk_gate_o.timer3_clk_en = (mode_r != PMW_STOP);
  assign clk_gate_o.wdt_reset_en = wdt_mode[1] & (in_run |
    (wdt_mode == WDT_ALWAYS));
  assign mode_o = mode_r;
  assign sysclk_sel_fast_o = sel_r;
  assign sysclk_tick_o = tick_r;
  assign wake_pulse_o = wake_r;
  assign bandgap_to_p32_o = aux_r[AUXILIARY_CONTROL_TWO_BGOUT_BIT];
  assign irq_flags_o = flag_r;
  assign irq_pending_o = |en_pend;
  assign irq_vector_o = vec;

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_b_i);

  sequence s_deep_req;
    wr_pwr && wd[PWR_SLEEP_BIT] && in_run;
  endsequence
  sequence s_back_run;
    ##1 (mode_r == PMW_FAST || mode_r == PMW_SLOW) && !doze_r && !sleep_r;
  endsequence

  refuse_deep_a: assert property (
    s_deep_req and refuse_deep |-> s_back_run)
    else $error("deep sleep entered with enabled pin low");
  halt_entry_a: assert property (s_deep_req and !refuse_deep &&
    !sstop_r |=> mode_r == PMW_HALT && clk_gate_o.slow_osc_en)
    else $error("halt not entered");
  stop_entry_a: assert property (s_deep_req and !refuse_deep &&
    sstop_r |=> mode_r == PMW_STOP && !clk_gate_o.slow_osc_en)
    else $error("stop not entered");
  idle_entry_a: assert property (doze_go && !sleep_go |=>
    mode_r == PMW_IDLE && !clk_gate_o.cpu_run)
    else $error("idle not entered");
  idle_wake_a: assert property (mode_r == PMW_IDLE && (|en_pend) |->
    s_back_run ##1 !wake_r)
    else $error("idle wake missing");
  stop_hold_a: assert property (mode_r == PMW_STOP && !pin_wake |=>
    mode_r == PMW_STOP)
    else $error("stop left without pin wake");
  div_settle_a: assert property ($changed(div_req_r) |->
    ##[0:16] div_eff_r == div_req_r)
    else $error("divider slow to apply");
  fstop_lock_a: assert property (
    mode_r != PMW_SLOW |=> $stable(fstop_r))
    else $error("fast stop changed outside slow");
  flag_set_a: assert property (
    (|ev) |=> (flag_r & $past(ev)) == $past(ev))
    else $error("event flag not set");
  sel_lock_a: assert property (fstop_r |=> $stable(sel_r))
    else $error("source changed with fast clock stopped");
  halt_hold_a: assert property (mode_r == PMW_HALT &&
    !pin_wake && !t3_wake |=> mode_r == PMW_HALT)
    else $error("halt left without wake source");
  stop_wake_a: assert property (mode_r == PMW_STOP && pin_wake |=>
    in_run && wake_r)
    else $error("stop not left on pin wake");
endmodule

`default_nettype wire

// ---- tb/pmw_src_model.sv ----
/*
  Peripheral and pin model: wake pins, port pins, one-cycle events.
  Assumes the bench commands it just after sys_clk_i edges.
*/
`timescale 1ns/10ps
`default_nettype none
module pmw_src_model
  import pmw_pkg::*;
(
  // Clock
  input wire logic sys_clk_i,
  // Bench commands
  input wire logic fire_i,
  input wire logic [3:0] src_i,
  input wire logic [2:0] pin_lvl_i,
  input wire logic [31:0] port_lvl_i,
  // Towards the block
  output logic [2:0] ext_irq_pin_o,
  output logic [31:0] port_pin_o,
  output logic [NUM_SRC-1:0] irq_event_o
);
  // ****************************************
  // Events and pins
  // ****************************************
  always @(posedge sys_clk_i) begin
    irq_event_o <= fire_i ? NUM_SRC'(1) << src_i : '0;
  end
  // Port pins move only when the bench says so
  assign port_pin_o = port_lvl_i;
  assign ext_irq_pin_o = pin_lvl_i;
endmodule
`default_nettype wire

// ---- tb/tb_power_mode_and_wakeup.sv ----
/*
  Self-checking bench for the power mode controller.
  Assumes one 100 MHz clock and the one-wait-cycle Avalon slave.
*/
`timescale 1ns/10ps
`default_nettype none
module tb_power_mode_and_wakeup
  import pmw_pkg::*;
;
  logic clk, rst_b, fire, wreq, tick, wake, bg, sel, pend;
  logic [3:0] src;
  logic [2:0] pins, extp;
  logic [31:0] rdata, rd, portp, portl;
  logic [4:0] mode;
  logic [12:0] flags, ev;
  logic [15:0] vec;
  pmw_avs_req_t req;
  pmw_clk_gate_t gate;
  int err_total, check_count, seed, n, off, wakes;
  int dv[4] = '{16, 4, 2, 1};
  int si[9] = '{1, 3, 4, 5, 6, 9, 10, 11, 12};
  logic [15:0] sv[9] = '{16'h000b, 16'h001b, 16'h0023, 16'h002b,
    16'h003b, 16'h0053, 16'h005b, 16'h0063, 16'h0073};

  pmw_src_model i_pmw_src_model(.sys_clk_i(clk), .fire_i(fire),
    .src_i(src), .pin_lvl_i(pins), .port_lvl_i(portl), .ext_irq_pin_o(extp),
    .port_pin_o(portp), .irq_event_o(ev));
  pmw_power_ctrl i_pmw_power_ctrl(.sys_clk_i(clk), .rst_b_i(rst_b),
    .avs_req_i(req), .avs_readdata_o(rdata), .avs_waitrequest_o(wreq),
    .ext_irq_pin_i(extp), .port_pin_i(portp), .irq_event_i(ev),
    .clk_gate_o(gate), .mode_o(mode), .sysclk_sel_fast_o(sel),
    .sysclk_tick_o(tick), .wake_pulse_o(wake), .bandgap_to_p32_o(bg),
    .irq_flags_o(flags), .irq_pending_o(pend), .irq_vector_o(vec));

  // ****************************************
  // Clock, watchdog, shared tasks
  // ****************************************
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    repeat (20000) @(posedge clk);
    err_total++;
    end_of_test();
  end
  always @(posedge clk) begin
    if (wake === 1'b1) wakes++;
  end
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] idx,
                     input logic [31:0] d);
    @(posedge clk);
    req.address <= {idx, 2'b00};
    req.write <= w;
    req.read <= ~w;
    req.writedata <= d;
    // Only the watchdog ends a wait that never gets its answer
    do begin
      @(posedge clk);
    end while (wreq !== 1'b0);
    rd = rdata;
    req.read <= 1'b0;
    req.write <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] idx, input logic [31:0] d);
    bus(1'b1, idx, d);
    // Written value lands on the answering edge; look one edge later
    @(posedge clk);
  endtask
  task automatic rc(input logic [7:0] idx, input logic [31:0] e);
    bus(1'b0, idx, 32'h0);
    chk(rd, e);
  endtask
  task automatic wm(input logic [4:0] e);
    int k;
    k = 0;
    while (mode !== e && k < 30) begin
      @(posedge clk);
      k++;
    end
    chk(mode, e);
  endtask
  task automatic pulse(input int s);
    @(posedge clk);
    src <= 4'(s);
    fire <= 1'b1;
    @(posedge clk);
    fire <= 1'b0;
    repeat (3) @(posedge clk);
  endtask
  task automatic fall();
    @(posedge clk);
    pins <= 3'h6;
    repeat (8) @(posedge clk);
    pins <= 3'h7;
    repeat (5) @(posedge clk);
  endtask
  task automatic et(input string s);
    $display("test %s done", s);
  endtask

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    seed = 4414;
    err_total = 0;
    check_count = 0;
    wakes = 0;
    rst_b = 1'b0;
    fire = 1'b0;
    src = 4'h0;
    pins = 3'h7;
    portl = 32'hffff_ffff;
    req = '0;
    req.byteenable = 4'hf;
    repeat (12) @(posedge clk);
    rst_b <= 1'b1;
    rc(IDX_PWR_CTRL, 32'h00);
    rc(IDX_CLK_CTRL, 32'h23);
    rc(IDX_AUXILIARY_CONTROL_TWO, 32'h06);
    rc(8'h10, 32'h0);
    chk(mode, PMW_SLOW);
    et("reset");
    for (int d = 0; d < 4; d++) begin
      wr(IDX_CLK_CTRL, 32'h20 | d);
      repeat (17) @(posedge clk);
      n = 0;
      repeat (32) begin
        @(posedge clk);
        n += int'(tick);
      end
      chk(n, 32 / dv[d]);
    end
    wr(IDX_AUXILIARY_CONTROL_TWO, 32'hd6);
    chk(bg, 1'b1);
    chk(gate.wdt_reset_en, 1'b1);
    wr(IDX_AUXILIARY_CONTROL_TWO, 32'h86);
    chk(bg, 1'b0);
    chk(gate.wdt_reset_en, 1'b1);
    et("clock");
    off = $unsigned($random(seed)) % 9;
    for (int k = 0; k < 9; k++) begin
      int i;
      i = (k + off) % 9;
      wr(IDX_IRQ_EN, 32'h0);
      pulse(si[i]);
      chk(flags, 13'(1) << si[i]);
      chk(vec, 16'h0000);
      wr(IDX_IRQ_EN, 32'h8000 | (1 << si[i]));
      chk(vec, sv[i]);
      chk(pend, 1'b1);
      chk(vec == 16'h0033 || vec == 16'h006b, 1'b0);
      wr(IDX_IRQ_FLAG, 32'h1fff);
      chk(flags, 13'h0);
    end
    et("vectors");
    wr(IDX_IRQ_EN, 32'h8002);
    wr(IDX_CLK_CTRL, 32'h13);
    wr(IDX_PWR_CTRL, 32'h01);
    wm(PMW_IDLE);
    chk(gate.cpu_run, 1'b0);
    chk(gate.periph_clk_en, 1'b0);
    chk(gate.timer3_clk_en, 1'b1);
    pulse(1);
    wm(PMW_SLOW);
    chk(gate.cpu_run, 1'b1);
    chk(gate.periph_clk_en, 1'b1);
    rc(IDX_PWR_CTRL, 32'h00);
    et("idle");
    wr(IDX_IRQ_FLAG, 32'h1fff);
    wr(IDX_CLK_CTRL, 32'h03);
    wr(IDX_IRQ_EN, 32'h0041);
    wr(IDX_PWR_CTRL, 32'h03);
    wm(PMW_HALT);
    chk(gate.fast_osc_en, 1'b0);
    chk(gate.timer3_clk_en, 1'b1);
    chk(gate.wdt_reset_en, 1'b0);
    pulse(6);
    wm(PMW_SLOW);
    wr(IDX_PWR_CTRL, 32'h02);
    wm(PMW_HALT);
    fall();
    wm(PMW_SLOW);
    et("halt");
    wr(IDX_CLK_CTRL, 32'h23);
    wr(IDX_PWR_CTRL, 32'h02);
    wm(PMW_STOP);
    chk(gate.slow_osc_en, 1'b0);
    chk(gate.timer3_clk_en, 1'b0);
    pulse(6);
    repeat (8) @(posedge clk);
    chk(mode, PMW_STOP);
    fall();
    wm(PMW_SLOW);
    rc(IDX_PWR_CTRL, 32'h00);
    pins <= 3'h6;
    repeat (6) @(posedge clk);
    wr(IDX_PWR_CTRL, 32'h02);
    repeat (6) @(posedge clk);
    chk(mode, PMW_SLOW);
    pins <= 3'h7;
    chk(wakes, 4);
    et("stop");
    wr(IDX_CLK_CTRL, 32'h0b);
    rc(IDX_CLK_CTRL, 32'h0b);
    chk(gate.fast_osc_en, 1'b0);
    wr(IDX_CLK_CTRL, 32'h0f);
    rc(IDX_CLK_CTRL, 32'h0b);
    wr(IDX_CLK_CTRL, 32'h03);
    wr(IDX_CLK_CTRL, 32'h07);
    wm(PMW_FAST);
    chk(sel, 1'b1);
    wr(IDX_CLK_CTRL, 32'h0f);
    rc(IDX_CLK_CTRL, 32'h07);
    bus(1'b0, IDX_STATUS, 32'h0);
    chk(rd[20:16], PMW_FAST);
    et("select");
    wr(IDX_IRQ_FLAG, 32'h1fff);
    wr(IDX_IRQ_EN, 32'h8080);
    wr(IDX_PORT_WAKE, 32'h100);
    portl <= 32'hffff_fdff;
    repeat (6) @(posedge clk);
    chk(flags, 13'h0);
    portl <= 32'hffff_fcff;
    repeat (6) @(posedge clk);
    chk(flags, 13'h080);
    chk(vec, 16'h0043);
    pins <= 3'h0;
    repeat (6) @(posedge clk);
    chk(flags, 13'h185);
    wr(IDX_IRQ_EN, 32'h8100);
    chk(vec, 16'h004b);
    wr(IDX_IRQ_EN, 32'h8104);
    chk(vec, 16'h0013);
    wr(IDX_IRQ_EN, 32'h8105);
    chk(vec, 16'h0003);
    pins <= 3'h7;
    et("pins");
    end_of_test();
  end
endmodule
`default_nettype wire
